// ==== nand_otp_area_access_test.sv ====
// Purpose: self-checking bench for the OTP area host controller
// Assumes: software-side reference model predicts status words and read bytes
// Notes: one operation at a time, busy polled through the status register
`timescale 1ns/100ps
module nand_otp_area_access_test;
  import nfo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic ce_n, cle, ale, we_n, re_n, io_oe, rb;
  logic rotp = 1'b0, rpm = 1'b0, rprot = 1'b0, rfail = 1'b0, rerr = 1'b0;
  logic [7:0] paddr, io_o, io_d, io_w, rst = 8'h00;
  logic [31:0] pwdata, prdata, rv;
  int rmem[int];
  int pend[int];
  int err_count = 0, n_tests = 0, rcnt = 0, rpage = 0, rlast = 0, c;
  assign io_w = io_oe ? io_o : io_d;
  nfo_otp_host nfo_otp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .read_enable_n(re_n), .nand_io_out(io_o), .nand_io_oe(io_oe), .nand_io_in(io_w),
    .ready_busy_n(rb));
  nfo_nand_dev nfo_nand_dev_i (.nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale),
    .nand_we_n(we_n), .read_enable_n(re_n), .nand_io(io_w), .nand_io_in(io_d),
    .ready_busy_n(rb));
  // ----------------------------------------------------------------
  // bus tasks and reference model
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [3:0] op, input logic [7:0] p1);
    apb(1'b1, REG_CTRL, {16'h0, p1, 4'h0, op});
    rv = 32'h1;
    while (rv[0] !== 1'b0) begin
      apb(1'b0, REG_STAT, 32'h0);
    end
  endtask
  function automatic int rd(input int pg, input int cl);
    int k;
    k = (int'(rotp) << 21) | (pg << 13) | cl;
    return rmem.exists(k) ? rmem[k] : 'hff;
  endfunction
  task automatic chk_stat();
    logic [31:0] m;
    m = rotp ? 32'h0007ff3f : 32'h0000ff3f;
    apb(1'b0, REG_STAT, 32'h0);
    chk("stat", {13'h0, rcnt[2:0], rst, 2'h0, rprot, rfail, rpm, rotp, rerr, 1'b0} & m, rv & m);
  endtask
  task automatic feat(input logic [7:0] p1);
    run(OP_FEAT, p1);
    rotp = (p1 == P1_OTP);
    rpm = (p1 == P1_PROTECT);
    chk_stat();
  endtask
  task automatic data(input int cl, input int n);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = rpm ? 8'h00 : 8'($urandom);
      pend[cl + i] = b;
      apb(1'b1, REG_WDATA, {24'h0, b});
      run(OP_WDATA, 8'h00);
    end
  endtask
  task automatic prog(input int pg, input int cl, input int n);
    logic rej;
    rej = rotp && (pg < 2 || pg > 'h31 || pg < rlast || (pg == rpage && rcnt == 4));
    rej = rej || (rpm && (pg != 0 || cl != 0));
    apb(1'b1, REG_COL, cl);
    apb(1'b1, REG_PAGE, pg);
    run(OP_PROG, 8'h00);
    rerr = rej;
    if (rej) begin
      chk_stat();
      apb(1'b1, REG_STAT, 32'h2);
      rerr = 1'b0;
      return;
    end
    if (rotp) begin
      rcnt = (pg == rpage) ? rcnt + 1 : 1;
      rpage = pg;
      rlast = pg;
    end
    pend.delete();
    data(cl, n);
    if (!rpm) begin
      apb(1'b1, REG_COL, cl + 'h40);
      run(OP_RAND_IN, 8'h00);
      data(cl + 'h40, 2);
    end
    run(OP_CONFIRM, 8'h00);
    rfail = rotp && rprot;
    if (rpm) rprot = 1'b1;
    else if (!rfail) foreach (pend[k]) rmem[(int'(rotp) << 21) | (pg << 13) | k] = rd(pg, k) & pend[k];
    rst = 8'he0 | rfail;
    chk_stat();
  endtask
  task automatic rchk(input int pg, input int cl, input int n, input logic [3:0] op);
    apb(1'b1, REG_COL, cl);
    apb(1'b1, REG_PAGE, pg);
    run(op, 8'h00);
    for (int i = 0; i < n; i++) begin
      run(OP_RDATA, 8'h00);
      apb(1'b0, REG_RDATA, 32'h0);
      chk("rdata", rd(pg, cl + i), {24'h0, rv[7:0]});
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (60000) @(posedge pclk);
    err_count++;
    end_of_test();
  end
  initial begin
    c = $urandom(32'h566254c6);
    c = $urandom_range(0, 'h1f00);
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_stat();
    apb(1'b0, 8'h20, 32'h0);
    chk("slverr", 32'h1, {31'h0, e});
    feat(P1_OTP);
    rchk(2, c, 2, OP_READ);
    repeat (5) prog(2, c, 3);
    rchk(2, c, 4, OP_READ);
    rchk(2, c + 'h40, 3, OP_RAND_OUT);
    prog(3, 0, 2);
    prog(2, 0, 1);
    prog(1, 0, 1);
    prog('h32, 0, 1);
    feat(P1_EXIT);
    prog(2, c, 2);
    feat(P1_OTP);
    rchk(2, c, 3, OP_READ);
    feat(P1_PROTECT);
    prog(1, 0, 1);
    prog(0, 0, 1);
    feat(P1_OTP);
    prog(4, 0, 2);
    rchk(4, 0, 2, OP_READ);
    rchk(3, 0, 2, OP_READ);
    run(OP_STATUS, 8'h00);
    chk_stat();
    end_of_test();
  end
endmodule

// ==== nfo_nand_dev.sv ====
// Purpose: behavioural OTP area device facing the host pins
// Assumes: commands, addresses and data latch on the rising write strobe
// Notes: busy times are short parameters; io shows inverted data when not driven
`timescale 1ns/100ps
module nfo_nand_dev #(
  parameter int T_PROG_NS = 400,
  parameter int T_OBSY_NS = 80,
  parameter int T_R_NS = 240
) (
  input wire logic nand_ce_n,
  input wire logic nand_cle,
  input wire logic nand_ale,
  input wire logic nand_we_n,
  input wire logic read_enable_n,
  input wire logic [7:0] nand_io,
  output logic [7:0] nand_io_in,
  output logic ready_busy_n
);
  logic [7:0] mem [int];
  logic [7:0] pend [int];
  logic [7:0] cmd = 8'h00, fadr = 8'h00, pg = 8'h00, q = 8'h00;
  logic [12:0] col = 13'h0, rptr = 13'h0;
  logic otp = 1'b0, pmode = 1'b0, prot = 1'b0, fail = 1'b0, sdrv = 1'b0, okp;
  int acnt = 0, dcnt = 0, bt = 0;
  event go;
  initial ready_busy_n = 1'b1;
  function automatic logic [7:0] rd(input logic [7:0] p, input logic [12:0] c);
    return mem.exists({otp, p, c}) ? mem[{otp, p, c}] : 8'hff;
  endfunction
  assign nand_io_in = (!nand_ce_n && !read_enable_n) ? q : ~q;
  task automatic confirm();
    okp = pend.size() == 1 && pend.exists(0) && pg == 8'h00;
    if (okp) okp = (pend[0] == 8'h00);
    bt = T_PROG_NS;
    if (pmode) begin
      fail = !okp;
      prot = prot | okp;
    end else if (otp && prot) begin
      fail = 1'b1;
      bt = T_OBSY_NS;
    end else begin
      fail = 1'b0;
      foreach (pend[c]) mem[{otp, pg, c[12:0]}] = rd(pg, c[12:0]) & pend[c];
    end
    ->go;
  endtask
  always @(posedge nand_we_n) begin
    if (!nand_ce_n && nand_cle) begin
      cmd = nand_io;
      acnt = 0;
      dcnt = 0;
      sdrv = (cmd == 8'h70);
      if (cmd == 8'h80 || cmd == 8'ha0 || cmd == 8'ha5) pend.delete();
      if (cmd == 8'h10) confirm();
      if (cmd == 8'h30) begin
        rptr = col;
        bt = T_R_NS;
        ->go;
      end
      if (cmd == 8'he0) rptr = col;
    end else if (!nand_ce_n && nand_ale) begin
      if (acnt == 0) col[7:0] = nand_io;
      if (acnt == 0) fadr = nand_io;
      if (acnt == 1) col[12:8] = nand_io[4:0];
      if (acnt == 2) pg = nand_io;
      acnt++;
    end else if (!nand_ce_n) begin
      if (cmd == 8'hef && dcnt == 0 && fadr == 8'h90) begin
        otp = (nand_io == 8'h01);
        pmode = (nand_io == 8'h03);
      end else if (cmd != 8'hef) begin
        pend[col] = nand_io;
        col++;
      end
      dcnt++;
    end
  end
  always @(negedge read_enable_n) q <= sdrv ? {1'b1, ready_busy_n, ready_busy_n, 4'h0, fail} : rd(pg, rptr);
  always @(posedge read_enable_n) if (!nand_ce_n && !sdrv) rptr++;
  always begin
    @(go);
    ready_busy_n = 1'b0;
    // release away from clock edges
    #(bt + 2);
    ready_busy_n = 1'b1;
  end
endmodule

// ==== nfo_otp_host.sv ====
// Purpose: host controller that drives OTP read, program and protect sequences on NAND pins
// Assumes: software launches one operation at a time via apb; pins sampled on pclk
// Notes: pready is always high; prdata is captured in the setup cycle
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module nfo_otp_host
  import nfo_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic nand_ce_n,
  output logic nand_cle,
  output logic nand_ale,
  output logic nand_we_n,
  output logic read_enable_n,
  output logic [7:0] nand_io_out,
  output logic nand_io_oe,
  input wire logic [7:0] nand_io_in,
  input wire logic ready_busy_n
);
  import nfo_pkg::*;

  nfo_state_e st_ff, nxt_st;
  logic [3:0] op_ff, idx_ff, cnt_ff;
  logic [7:0] param_ff, page_ff, wdata_ff, rdata_ff, status_ff, last_page_ff, part_page_ff;
  logic [12:0] col_ff;
  logic [2:0] part_cnt_ff;
  logic err_ff, fail_ff, otp_ff, prot_ff, protected_ff;
  logic ce_n_ff, cle_ff, ale_ff, we_n_ff, re_n_ff, io_oe_ff;
  logic [7:0] io_out_ff;
  logic [31:0] prdata_ff;

  // ----------------------------------------------------------------
  // step table: kind and byte of each pin cycle
  // ----------------------------------------------------------------
  function automatic logic [10:0] step_fn(input logic [3:0] op, input logic [3:0] i,
                                          input logic [7:0] p1, input logic [12:0] col,
                                          input logic [7:0] pg, input logic [7:0] wd);
    logic [7:0] c0;
    logic [7:0] c1;
    logic [10:0] r;
    c0 = col[7:0];
    c1 = {3'h0, col[12:8]};
    r = {K_END, 8'h00};
    case (op)
      OP_FEAT: begin
        case (i)
          4'h0: r = {K_CMD, NC_SET_FEAT};
          4'h1: r = {K_ADDR, NC_FEAT_OTP};
          4'h2: r = {K_DIN, p1};
          4'h3, 4'h4, 4'h5: r = {K_DIN, 8'h00};
          4'h6: r = {K_WAIT, 8'h00};
          default: r = {K_END, 8'h00};
        endcase
      end
      OP_PROG, OP_READ: begin
        case (i)
          4'h0: r = {K_CMD, (op == OP_PROG) ? NC_PROG1 : NC_READ1};
          4'h1: r = {K_ADDR, c0};
          4'h2: r = {K_ADDR, c1};
          4'h3: r = {K_ADDR, pg};
          4'h4, 4'h5: r = {K_ADDR, 8'h00};
          4'h6: r = (op == OP_READ) ? {K_CMD, NC_READ2} : {K_END, 8'h00};
          4'h7: r = (op == OP_READ) ? {K_WAIT, 8'h00} : {K_END, 8'h00};
          default: r = {K_END, 8'h00};
        endcase
      end
      OP_RAND_IN, OP_RAND_OUT: begin
        case (i)
          4'h0: r = {K_CMD, (op == OP_RAND_IN) ? NC_RAND_IN : NC_RAND_OUT1};
          4'h1: r = {K_ADDR, c0};
          4'h2: r = {K_ADDR, c1};
          4'h3: r = (op == OP_RAND_OUT) ? {K_CMD, NC_RAND_OUT2} : {K_END, 8'h00};
          default: r = {K_END, 8'h00};
        endcase
      end
      OP_WDATA: r = (i == 4'h0) ? {K_DIN, wd} : {K_END, 8'h00};
      OP_RDATA: r = (i == 4'h0) ? {K_DOUT, 8'h00} : {K_END, 8'h00};
      OP_STATUS: begin
        case (i)
          4'h0: r = {K_CMD, NC_STATUS};
          4'h1: r = {K_DOUT, 8'h00};
          default: r = {K_END, 8'h00};
        endcase
      end
      OP_CONFIRM: begin
        case (i)
          4'h0: r = {K_CMD, NC_PROG2};
          4'h1: r = {K_WAIT, 8'h00};
          4'h2: r = {K_CMD, NC_STATUS};
          4'h3: r = {K_DOUT, 8'h00};
          default: r = {K_END, 8'h00};
        endcase
      end
      default: r = {K_END, 8'h00};
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // apb decode and launch checks
  // ----------------------------------------------------------------
  wire busy = (st_ff != ST_IDLE);
  wire apb_wr = psel && penable && pwrite;
  wire hit_ctrl = (paddr == REG_CTRL);
  wire mapped = hit_ctrl || (paddr == REG_COL) || (paddr == REG_PAGE) ||
                (paddr == REG_WDATA) || (paddr == REG_STAT) || (paddr == REG_RDATA);
  wire launch_req = apb_wr && hit_ctrl && !busy;
  wire [3:0] req_op = pwdata[3:0];
  wire [7:0] req_p1 = pwdata[15:8];
  wire page_in_range = (page_ff >= OTP_PAGE_MIN) && (page_ff <= OTP_PAGE_MAX);
  wire bad_range = otp_ff && (req_op == OP_PROG || req_op == OP_READ) && !page_in_range;
  wire bad_order = otp_ff && (req_op == OP_PROG) && (page_ff < last_page_ff);
  wire bad_part = otp_ff && (req_op == OP_PROG) && (page_ff == part_page_ff) &&
                  (part_cnt_ff == MAX_PARTIAL);
  wire bad_prot = prot_ff && ((req_op == OP_PROG && (page_ff != 8'h00 || col_ff != 13'h0)) ||
                  (req_op == OP_WDATA && wdata_ff != 8'h00));
  wire bad_op = (req_op > OP_STATUS);
  wire reject = launch_req && (bad_range || bad_order || bad_part || bad_prot || bad_op);
  wire launch = launch_req && !reject;
  wire [10:0] step = step_fn(op_ff, idx_ff, param_ff, col_ff, page_ff, wdata_ff);
  wire [2:0] kind = step[10:8];
  wire is_dout = (kind == K_DOUT);
  wire phase_end = (cnt_ff == 4'h1);
  wire done = (st_ff == ST_STEP) && (kind == K_END);
  wire err_clr = apb_wr && (paddr == REG_STAT) && pwdata[STAT_ERR_BIT];
  wire conf_done = done && (op_ff == OP_CONFIRM);
  wire feat_done = done && (op_ff == OP_FEAT);
  wire prog_launch = launch && (req_op == OP_PROG);

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && hit_ctrl && busy));
  assign prdata = prdata_ff;

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_IDLE: if (launch) nxt_st = ST_STEP;
      ST_STEP: begin
        if (kind == K_END) nxt_st = ST_IDLE;
        else if (kind == K_WAIT) nxt_st = ST_WB;
        else nxt_st = ST_LO;
      end
      ST_LO: if (phase_end) nxt_st = ST_HI;
      ST_HI: if (phase_end) nxt_st = ST_STEP;
      ST_WB: if (phase_end) nxt_st = ST_RDY;
      ST_RDY: if (ready_busy_n) nxt_st = ST_STEP;
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= ST_IDLE;
      idx_ff <= 4'h0;
      cnt_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      if (launch) idx_ff <= 4'h0;
      else if ((st_ff == ST_HI || st_ff == ST_RDY) && nxt_st == ST_STEP) idx_ff <= idx_ff + 4'h1;
      if (st_ff == ST_STEP && kind == K_WAIT) cnt_ff <= CYC_WB;
      else if (st_ff == ST_STEP) cnt_ff <= is_dout ? CYC_RP : CYC_WP;
      else if (st_ff == ST_LO && phase_end) cnt_ff <= is_dout ? CYC_REH : CYC_WH;
      else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ce_n_ff <= 1'b1;
      cle_ff <= 1'b0;
      ale_ff <= 1'b0;
      we_n_ff <= 1'b1;
      re_n_ff <= 1'b1;
      io_oe_ff <= 1'b0;
      io_out_ff <= 8'h00;
    end else begin
      ce_n_ff <= (nxt_st == ST_IDLE);
      if (st_ff == ST_STEP && kind <= K_DOUT) begin
        // commands and addresses no cache read opcode
        cle_ff <= (kind == K_CMD);
        ale_ff <= (kind == K_ADDR);
        io_out_ff <= step[7:0];
        io_oe_ff <= !is_dout;
        we_n_ff <= is_dout;
        re_n_ff <= !is_dout;
      end else if (st_ff == ST_LO && phase_end) begin
        we_n_ff <= 1'b1;
        re_n_ff <= 1'b1;
      end else if (nxt_st == ST_IDLE) begin
        cle_ff <= 1'b0;
        ale_ff <= 1'b0;
        io_oe_ff <= 1'b0;
      end
    end
  end

  assign nand_ce_n = ce_n_ff;
  assign nand_cle = cle_ff;
  assign nand_ale = ale_ff;
  assign nand_we_n = we_n_ff;
  assign read_enable_n = re_n_ff;
  assign nand_io_out = io_out_ff;
  assign nand_io_oe = io_oe_ff;

  // ----------------------------------------------------------------
  // software registers and mode tracking
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_ff <= OP_FEAT;
      param_ff <= 8'h00;
      col_ff <= 13'h0;
      page_ff <= 8'h00;
      wdata_ff <= 8'h00;
      rdata_ff <= 8'h00;
      status_ff <= 8'h00;
      err_ff <= 1'b0;
      fail_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      if (launch) op_ff <= req_op;
      if (launch) param_ff <= req_p1;
      if (apb_wr && paddr == REG_COL && !busy) col_ff <= pwdata[12:0];
      if (apb_wr && paddr == REG_PAGE && !busy) page_ff <= pwdata[7:0];
      if (apb_wr && paddr == REG_WDATA && !busy) wdata_ff <= pwdata[7:0];
      if (st_ff == ST_LO && phase_end && is_dout) begin
        // one byte per read_enable_n pulse
        if (op_ff == OP_STATUS || op_ff == OP_CONFIRM) status_ff <= nand_io_in;
        else rdata_ff <= nand_io_in;
      end
      if (reject) err_ff <= 1'b1;
      else if (err_clr) err_ff <= 1'b0;
      if (conf_done) fail_ff <= status_ff[0];
      if (psel && !penable) begin
        case (paddr)
          REG_CTRL: prdata_ff <= {20'h0, param_ff, op_ff};
          REG_COL: prdata_ff <= {19'h0, col_ff};
          REG_PAGE: prdata_ff <= {24'h0, page_ff};
          REG_WDATA: prdata_ff <= {24'h0, wdata_ff};
          REG_STAT: prdata_ff <= {13'h0, part_cnt_ff, status_ff, 2'h0, protected_ff, fail_ff,
                                  prot_ff, otp_ff, err_ff, busy};
          REG_RDATA: prdata_ff <= {24'h0, rdata_ff};
          default: prdata_ff <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      otp_ff <= 1'b0;
      prot_ff <= 1'b0;
      protected_ff <= 1'b0;
      last_page_ff <= 8'h00;
      part_page_ff <= 8'h00;
      part_cnt_ff <= 3'h0;
    end else begin
      if (feat_done) begin
        otp_ff <= (param_ff == P1_OTP);
        prot_ff <= (param_ff == P1_PROTECT);
      end
      // protection is permanent
      if (conf_done && prot_ff && !status_ff[0]) protected_ff <= 1'b1;
      if (prog_launch && otp_ff) begin
        // ascending order and partial count
        last_page_ff <= page_ff;
        if (page_ff != part_page_ff) part_page_ff <= page_ff;
        if (page_ff != part_page_ff) part_cnt_ff <= 3'h1;
        else part_cnt_ff <= part_cnt_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
    launch_req && otp_ff && (req_op == OP_PROG || req_op == OP_READ) &&
    (page_ff < OTP_PAGE_MIN || page_ff > OTP_PAGE_MAX) |=> err_ff && !busy)
    else $error("out of range otp page was launched");
  AST_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
    launch_req && otp_ff && req_op == OP_PROG && page_ff < last_page_ff |=> err_ff && !busy)
    else $error("descending otp program was launched");
  AST_PARTIAL: assert property (@(posedge pclk) disable iff (!presetn)
    part_cnt_ff <= MAX_PARTIAL)
    else $error("more than four partial programs counted");
  AST_PROT_ADDR: assert property (@(posedge pclk) disable iff (!presetn)
    launch && prot_ff && req_op == OP_PROG |-> page_ff == 8'h00 && col_ff == 13'h0)
    else $error("protect sequence with nonzero address");
  AST_FEAT_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    feat_done && param_ff == P1_OTP |=> otp_ff && !prot_ff)
    else $error("otp mode not entered");
  AST_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
    feat_done && param_ff == P1_EXIT |=> !otp_ff && !prot_ff)
    else $error("otp modes not left");
  AST_WAIT_RB: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ST_RDY && !ready_busy_n |=> st_ff == ST_RDY && nand_we_n && read_enable_n)
    else $error("sequence moved on while device busy");
  // cycles spent so far in the busy window
  logic [3:0] wb_len_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wb_len_ff <= 4'h0;
    end else begin
      wb_len_ff <= (st_ff == ST_WB) ? wb_len_ff + 4'h1 : 4'h0;
    end
  end
  AST_TWB: assert property (@(posedge pclk) disable iff (!presetn)
    st_ff == ST_WB |-> nand_we_n && (!phase_end || wb_len_ff == CYC_WB - 4'h1))
    else $error("busy wait shorter than expected");
  AST_FAIL: assert property (@(posedge pclk) disable iff (!presetn)
    conf_done |=> fail_ff == $past(status_ff[0]))
    else $error("pass fail flag not taken from status bit 0");
  AST_STROBE: assert property (@(posedge pclk) disable iff (!presetn)
    !read_enable_n |-> nand_we_n && !nand_io_oe && !nand_ce_n)
    else $error("read strobe overlaps a write");
  AST_PROT_PERM: assert property (@(posedge pclk) disable iff (!presetn)
    protected_ff || (conf_done && prot_ff && !status_ff[0]) |=> protected_ff)
    else $error("protection flag not kept");
  AST_IDLE_PINS: assert property (@(posedge pclk) disable iff (!presetn)
    !busy |-> nand_ce_n && nand_we_n && read_enable_n && !nand_io_oe)
    else $error("nand pins active while idle");
  COV_PROG: cover property (@(posedge pclk) disable iff (!presetn) conf_done && otp_ff);
  COV_PROTECT: cover property (@(posedge pclk) disable iff (!presetn) conf_done && prot_ff);
  COV_REJECT: cover property (@(posedge pclk) disable iff (!presetn) reject);
  COV_READ: cover property (@(posedge pclk) disable iff (!presetn) done && op_ff == OP_READ);
  COV_LOCKED: cover property (@(posedge pclk) disable iff (!presetn)
    conf_done && otp_ff && protected_ff);
endmodule

// ==== nfo_pkg.sv ====
// Purpose: constants for the host-side OTP area controller of an 8-bit NAND device
// Assumes: 125 MHz pclk, APB slave for software, NAND pins synchronous to pclk
// Notes: op codes are written to the control register to launch a pin sequence
package nfo_pkg;
  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_COL = 8'h04;
  localparam logic [7:0] REG_PAGE = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_STAT = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam int STAT_ERR_BIT = 1;
  // ----------------------------------------------------------------
  // operations launched through the control register
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_FEAT = 4'h0;
  localparam logic [3:0] OP_PROG = 4'h1;
  localparam logic [3:0] OP_RAND_IN = 4'h2;
  localparam logic [3:0] OP_WDATA = 4'h3;
  localparam logic [3:0] OP_CONFIRM = 4'h4;
  localparam logic [3:0] OP_READ = 4'h5;
  localparam logic [3:0] OP_RAND_OUT = 4'h6;
  localparam logic [3:0] OP_RDATA = 4'h7;
  localparam logic [3:0] OP_STATUS = 4'h8;
  // ----------------------------------------------------------------
  // nand opcodes, feature values, page range
  // ----------------------------------------------------------------
  localparam logic [7:0] NC_SET_FEAT = 8'hef;
  localparam logic [7:0] NC_FEAT_OTP = 8'h90;
  localparam logic [7:0] NC_READ1 = 8'h00;
  localparam logic [7:0] NC_READ2 = 8'h30;
  localparam logic [7:0] NC_PROG1 = 8'h80;
  localparam logic [7:0] NC_PROG2 = 8'h10;
  localparam logic [7:0] NC_RAND_IN = 8'h85;
  localparam logic [7:0] NC_RAND_OUT1 = 8'h05;
  localparam logic [7:0] NC_RAND_OUT2 = 8'he0;
  localparam logic [7:0] NC_STATUS = 8'h70;
  localparam logic [7:0] P1_EXIT = 8'h00;
  localparam logic [7:0] P1_OTP = 8'h01;
  localparam logic [7:0] P1_PROTECT = 8'h03;
  localparam logic [7:0] OTP_PAGE_MIN = 8'h02;
  localparam logic [7:0] OTP_PAGE_MAX = 8'h31;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  // ----------------------------------------------------------------
  // step kinds of a pin sequence
  // ----------------------------------------------------------------
  localparam logic [2:0] K_CMD = 3'h0;
  localparam logic [2:0] K_ADDR = 3'h1;
  localparam logic [2:0] K_DIN = 3'h2;
  localparam logic [2:0] K_DOUT = 3'h3;
  localparam logic [2:0] K_WAIT = 3'h4;
  localparam logic [2:0] K_END = 3'h5;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 8;
  localparam int T_WP_NS = 15;
  localparam int T_WH_NS = 10;
  localparam int T_RP_NS = 15;
  localparam int T_REH_NS = 10;
  localparam int T_WB_NS = 100;
  localparam logic [3:0] CYC_WP = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_WH = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_RP = 4'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_REH = 4'((T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] CYC_WB = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {ST_IDLE, ST_STEP, ST_LO, ST_HI, ST_WB, ST_RDY} nfo_state_e;
endpackage
